// ==== core/dma_channel_engine.sv ====
// Purpose: four-channel transfer controller engine with short and full address modes
// Assumes: peripheral events are one-cycle pulses on CLK; ext request pins are asynchronous
// Notes: one shared memory master port; lowest channel number wins arbitration
// Notes on behaviour
// R1: short address mode: four independent channels, external requests only on B channels.
// R2: full address mode pairs A and B; auto-request offers burst or cycle-steal.
// R3: each channel picks io or idle mode independently of the others.
// R4: io mode moves one byte or word per accepted request, repeated count times.
// R5: receive-full trigger copies io to memory; every other trigger memory to io.
// R6: io-side address is ones in upper sixteen bits, register byte below, never stepped.
// R7: io mode steps memory address up or down after every unit moved.
// R8: io mode count drops per transfer; at zero enable clears, interrupt if enabled.
// R9: starting count zero means 65536 transfers in io and idle modes.
// R10: requesters are timer matches 0-3, serial empty/full, or external request.
// R11: idle mode keeps memory and io addresses constant.
// R12: idle mode at zero count clears enable, stops, and raises interrupt.
// R13: repeat mode restores address and count after the run, never interrupts.
// R14: auto-request normal mode starts on enable alone and runs to count end.
// R15: cycle-steal releases the bus after every single unit moved.
// R16: burst holds the bus until done unless a higher master asks.
// R17: external-request normal mode moves one unit per request with two full addresses.
// R18: block mode moves a block per request and rewinds block-side address.
// R19: block size counter reloads at zero; block counter ends transfer at zero.
// R20: address step is one for bytes and two for words.
// R21: enable is set only by a read with enable clear, then writing one.
// R22: repeat counter reloads at zero and address rewinds by step times count.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_engine import dma_pkg::*; #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // request sources
    input wire logic [3:0] TMR_MATCH,
    input wire logic SER_TXE,
    input wire logic SER_RXF,
    input wire logic [NCH/2-1:0] EXT_REQ_N,
    // memory master
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic MEM_WORD,
    output logic [23:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_ACK,
    input wire logic BUS_YIELD,
    output logic BUS_LOCK,
    // completion
    output logic [NCH-1:0] DONE_IRQ
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic w, input logic dec);
        logic [23:0] d;
        d = w ? 24'h000002 : 24'h000001; // R20
        return dec ? a - d : a + d;
    endfunction
    // rewind by step times n, n of zero meaning 256
    function automatic logic [23:0] rewind(input logic [23:0] a, input logic w, input logic dec,
                                           input logic [7:0] n);
        logic [23:0] d;
        d = {15'h0000, (n == 8'h00), n} << w;
        return dec ? a + d : a - d; // R22
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction

    logic [23:0] mar_reg [NCH];
    logic [7:0] short_io_address_reg [NCH];
    logic [15:0] cnt_reg [NCH];
    logic [CTL_W-1:0] ctl_reg [NCH];
    logic [NCH/2-1:0] master_reg;
    logic [NCH-1:0] armed_reg;
    logic [NCH-1:0] pend_reg;
    logic [NCH/2-1:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
    eng_t state_reg;
    logic [1:0] cur_reg;
    logic [15:0] data_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;

    ////////////////////////////////////////////////////////////////////////
    // bus decode; single-cycle ack, unmapped reads zero
    logic wb_req, wb_done, wb_wr, wb_rd, wb_ch_hit, wb_master_hit;
    logic [1:0] wb_ch, wb_sub;
    assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;
    // writes land on the edge at which the master sees ack
    assign wb_done = WB_CYC_I && WB_STB_I && ack_reg;
    assign wb_wr = wb_done && WB_WE_I;
    assign wb_rd = wb_req && !WB_WE_I;
    assign wb_ch = WB_ADR_I[5:4];
    assign wb_sub = WB_ADR_I[3:2];
    assign wb_ch_hit = (WB_ADR_I[7:6] == 2'b00) && (32'(wb_ch) < NCH);
    assign wb_master_hit = (WB_ADR_I[7:2] == OFF_MASTER_ENABLE[7:2]);

    always_ff @(posedge CLK) begin
        if (SYS_RST) ack_reg <= 1'b0;
        else ack_reg <= wb_req;
    end
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdat_reg <= 32'h00000000;
        end else if (wb_rd && wb_master_hit) begin
            rdat_reg <= 32'(master_reg);
        end else if (wb_rd && wb_ch_hit && {wb_sub, 2'b00} == OFF_MEMORY_ADDRESS[3:0]) begin
            rdat_reg <= {8'h00, mar_reg[wb_ch]};
        end else if (wb_rd && wb_ch_hit && {wb_sub, 2'b00} == OFF_SHORT_IO_ADDRESS[3:0]) begin
            rdat_reg <= {24'h000000, short_io_address_reg[wb_ch]};
        end else if (wb_rd && wb_ch_hit && {wb_sub, 2'b00} == OFF_TRANSFER_COUNT[3:0]) begin
            rdat_reg <= {16'h0000, cnt_reg[wb_ch]};
        end else if (wb_rd && wb_ch_hit) begin
            rdat_reg <= {20'h00000, ctl_reg[wb_ch]};
        end else if (wb_rd) begin
            rdat_reg <= 32'h00000000;
        end
    end

    // read-then-write guard for the enable bit
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            armed_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wb_ch_hit && 32'(wb_ch) == c && {wb_sub, 2'b00} == OFF_CONTROL[3:0] && wb_done)
                    armed_reg[c] <= !WB_WE_I && !ctl_reg[c][CTL_ENABLE]; // R21
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) master_reg <= '0;
        else if (wb_wr && wb_master_hit && WB_SEL_I[0]) master_reg <= WB_DAT_I[NCH/2-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // request capture; ext pins synchronised, falling edge taken
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ext_s1_reg <= '1;
            ext_s2_reg <= '1;
            ext_s3_reg <= '1;
        end else begin
            ext_s1_reg <= EXT_REQ_N;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    logic [NCH-1:0] full_ch, active, trig, auto_ch;
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            logic [2:0] sel, md;
            logic ext_edge;
            sel = ctl_reg[c][CTL_TRIG_LO +: 3];
            md = ctl_reg[c][CTL_MODE_LO +: 3];
            ext_edge = ext_s3_reg[c/2] && !ext_s2_reg[c/2];
            // pairing decided by the A channel's mode
            full_ch[c] = ctl_reg[c & ~1][CTL_MODE_LO +: 3] >= 3'(M_AUTO_BURST); // R2
            auto_ch[c] = md == 3'(M_AUTO_BURST) || md == 3'(M_AUTO_STEAL);
            active[c] = ctl_reg[c][CTL_ENABLE] && master_reg[c/2] && !(full_ch[c] && c[0]);
            if (sel[2] == 1'b0) trig[c] = TMR_MATCH[sel[1:0]]; // R10
            else if (sel == TRIG_TXE) trig[c] = SER_TXE;
            else if (sel == TRIG_RXF) trig[c] = SER_RXF;
            // only a B pin can request; in full mode the A engine uses its pair's pin
            else if (sel == TRIG_EXT) trig[c] = ext_edge && (c[0] || full_ch[c]); // R1
            else trig[c] = 1'b0;
        end
    end

    // arbitration: lowest channel number first
    logic [NCH-1:0] ready;
    logic [1:0] pick;
    logic any_ready;
    assign ready = active & (pend_reg | auto_ch); // R14
    always_comb begin
        pick = 2'd0;
        any_ready = 1'b0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (ready[c]) begin
                pick = 2'(c);
                any_ready = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current transfer: addresses and next register values
    logic [2:0] cm;
    logic cw, rx_dir, short_m, last_unit, block_end, xfer_done, stay;
    logic [1:0] cb;
    logic [23:0] io_full, src_addr, dst_addr, nmar_a, nmar_b;
    logic [15:0] ncnt_a, ncnt_b;
    logic [7:0] blk_init;
    always_comb begin
        cm = ctl_reg[cur_reg][CTL_MODE_LO +: 3];
        cb = cur_reg | 2'd1;
        cw = ctl_reg[cur_reg][CTL_WORD];
        short_m = cm <= 3'(M_REPEAT);
        rx_dir = ctl_reg[cur_reg][CTL_TRIG_LO +: 3] == TRIG_RXF;
        io_full = {IO_HIGH_ONES, short_io_address_reg[cur_reg]}; // R6
        src_addr = mar_reg[cur_reg];
        dst_addr = mar_reg[cb];
        if (short_m && rx_dir) begin
            src_addr = io_full; // R5
            dst_addr = mar_reg[cur_reg];
        end else if (short_m) begin
            dst_addr = io_full;
        end
        nmar_a = mar_reg[cur_reg];
        nmar_b = mar_reg[cb];
        ncnt_a = cnt_reg[cur_reg] - 16'h0001; // R9
        ncnt_b = cnt_reg[cb];
        blk_init = cnt_reg[cur_reg][7:0];
        last_unit = 1'b0;
        block_end = 1'b0;
        case (cm)
            3'(M_IO): begin
                nmar_a = step_addr(mar_reg[cur_reg], cw, ctl_reg[cur_reg][CTL_DEC]); // R7
                last_unit = ncnt_a == 16'h0000; // R8
            end
            3'(M_IDLE): begin
                last_unit = ncnt_a == 16'h0000; // R12 R11
            end
            3'(M_REPEAT): begin
                nmar_a = step_addr(mar_reg[cur_reg], cw, ctl_reg[cur_reg][CTL_DEC]);
                ncnt_a = {cnt_reg[cur_reg][15:8] - 8'h01, blk_init};
                if (ncnt_a[15:8] == 8'h00) begin
                    ncnt_a = {blk_init, blk_init}; // R13 R22
                    nmar_a = rewind(nmar_a, cw, ctl_reg[cur_reg][CTL_DEC], blk_init);
                end
            end
            3'(M_BLOCK): begin
                if (ctl_reg[cur_reg][CTL_STEP_EN])
                    nmar_a = step_addr(mar_reg[cur_reg], cw, ctl_reg[cur_reg][CTL_DEC]);
                if (ctl_reg[cb][CTL_STEP_EN])
                    nmar_b = step_addr(mar_reg[cb], cw, ctl_reg[cb][CTL_DEC]);
                ncnt_a = {cnt_reg[cur_reg][15:8] - 8'h01, blk_init}; // R19
                if (ncnt_a[15:8] == 8'h00) begin
                    block_end = 1'b1;
                    ncnt_a = {blk_init, blk_init};
                    ncnt_b = cnt_reg[cb] - 16'h0001;
                    last_unit = ncnt_b == 16'h0000; // R19
                    if (ctl_reg[cb][CTL_SRC_BLOCK])
                        nmar_a = rewind(nmar_a, cw, ctl_reg[cur_reg][CTL_DEC], blk_init); // R18
                    else
                        nmar_b = rewind(nmar_b, cw, ctl_reg[cb][CTL_DEC], blk_init); // R18
                end
            end
            default: begin
                // normal modes: two full addresses stepped on their own settings
                if (ctl_reg[cur_reg][CTL_STEP_EN])
                    nmar_a = step_addr(mar_reg[cur_reg], cw, ctl_reg[cur_reg][CTL_DEC]); // R17
                if (ctl_reg[cb][CTL_STEP_EN])
                    nmar_b = step_addr(mar_reg[cb], cw, ctl_reg[cb][CTL_DEC]);
                last_unit = ncnt_a == 16'h0000;
            end
        endcase
        xfer_done = state_reg == S_WR && MEM_ACK;
        // burst keeps going; a block in progress is one request
        stay = active[cur_reg] && !last_unit && !BUS_YIELD &&
               (cm == 3'(M_AUTO_BURST) || (cm == 3'(M_BLOCK) && !block_end)); // R16 R18
    end

    ////////////////////////////////////////////////////////////////////////
    // channel registers: software write wins over an engine update
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int c = 0; c < NCH; c++) begin
                mar_reg[c] <= MAR_RESET;
                short_io_address_reg[c] <= 8'h00;
                cnt_reg[c] <= CNT_RESET;
                ctl_reg[c] <= CTL_RESET;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                logic hit;
                logic [31:0] wv;
                hit = wb_wr && wb_ch_hit && 32'(wb_ch) == c;
                if (hit && {wb_sub, 2'b00} == OFF_MEMORY_ADDRESS[3:0]) begin
                    wv = merge({8'h00, mar_reg[c]}, WB_DAT_I, WB_SEL_I);
                    mar_reg[c] <= wv[23:0];
                end else if (xfer_done && 2'(c) == cur_reg) begin
                    mar_reg[c] <= nmar_a;
                end else if (xfer_done && 2'(c) == cb && !short_m) begin
                    mar_reg[c] <= nmar_b;
                end
                if (hit && {wb_sub, 2'b00} == OFF_SHORT_IO_ADDRESS[3:0] && WB_SEL_I[0])
                    short_io_address_reg[c] <= WB_DAT_I[7:0];
                if (hit && {wb_sub, 2'b00} == OFF_TRANSFER_COUNT[3:0]) begin
                    wv = merge({16'h0000, cnt_reg[c]}, WB_DAT_I, WB_SEL_I);
                    cnt_reg[c] <= wv[15:0];
                end else if (xfer_done && 2'(c) == cur_reg) begin
                    cnt_reg[c] <= ncnt_a; // R4
                end else if (xfer_done && 2'(c) == cb && cm == 3'(M_BLOCK)) begin
                    cnt_reg[c] <= ncnt_b;
                end
                if (hit && {wb_sub, 2'b00} == OFF_CONTROL[3:0]) begin
                    wv = merge({20'h00000, ctl_reg[c]}, WB_DAT_I, WB_SEL_I);
                    // a one lands on enable only after the arming read
                    wv[CTL_ENABLE] = wv[CTL_ENABLE] && (ctl_reg[c][CTL_ENABLE] || armed_reg[c]); // R21
                    ctl_reg[c] <= wv[CTL_W-1:0]; // R3
                end else if (xfer_done && 2'(c) == cur_reg && last_unit) begin
                    ctl_reg[c][CTL_ENABLE] <= 1'b0; // R8 R12
                end
            end
        end
    end

    // pending requests; a new trigger in the take cycle survives
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pend_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (!active[c]) pend_reg[c] <= 1'b0;
                else if (trig[c]) pend_reg[c] <= 1'b1;
                else if (state_reg == S_IDLE && any_ready && 2'(c) == pick) pend_reg[c] <= 1'b0; // R4
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DONE_IRQ <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                logic md_io, md_idle;
                md_io = ctl_reg[c][CTL_MODE_LO +: 3] != 3'(M_REPEAT);
                md_idle = ctl_reg[c][CTL_MODE_LO +: 3] == 3'(M_IDLE);
                // idle mode always interrupts; repeat never finishes
                DONE_IRQ[c] <= xfer_done && 2'(c) == cur_reg && last_unit && md_io &&
                               (ctl_reg[c][CTL_IRQ_EN] || md_idle); // R8 R12 R13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine: read phase then write phase on the memory master
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= S_IDLE;
            cur_reg <= 2'd0;
            data_reg <= 16'h0000;
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_WORD <= 1'b0;
            MEM_ADDR <= 24'h000000;
            MEM_WDATA <= 16'h0000;
            BUS_LOCK <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    MEM_REQ <= 1'b0;
                    BUS_LOCK <= 1'b0;
                    if (any_ready) begin
                        cur_reg <= pick;
                        state_reg <= S_RD;
                    end
                end
                S_RD: begin
                    if (!MEM_REQ) begin
                        MEM_REQ <= 1'b1;
                        MEM_WE <= 1'b0;
                        MEM_WORD <= cw;
                        MEM_ADDR <= src_addr;
                        BUS_LOCK <= cm == 3'(M_AUTO_BURST) || cm == 3'(M_BLOCK);
                    end else if (MEM_ACK) begin
                        data_reg <= MEM_RDATA;
                        MEM_WE <= 1'b1;
                        MEM_ADDR <= dst_addr;
                        MEM_WDATA <= MEM_RDATA;
                        state_reg <= S_WR;
                    end
                end
                S_WR: begin
                    if (MEM_ACK) begin
                        MEM_REQ <= 1'b0;
                        MEM_WE <= 1'b0;
                        // cycle steal and request modes give the bus back here
                        state_reg <= stay ? S_RD : S_IDLE; // R15 R16
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_xfer_last;
        xfer_done && last_unit && cm != 3'(M_REPEAT);
    endsequence
    sequence s_steal_done;
        xfer_done && cm == 3'(M_AUTO_STEAL);
    endsequence

    a_ack_single: assert property (@(posedge CLK) disable iff (SYS_RST)
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
    a_done_clears_enable: assert property (@(posedge CLK) disable iff (SYS_RST) // R8
        s_xfer_last ##0 !wb_wr |=> !ctl_reg[$past(cur_reg)][CTL_ENABLE]) else $error("enable not cleared");
    a_irq_needs_done: assert property (@(posedge CLK) disable iff (SYS_RST) // R12
        DONE_IRQ[cur_reg] |-> $past(xfer_done) && $past(last_unit)) else $error("stray completion pulse");
    a_steal_release: assert property (@(posedge CLK) disable iff (SYS_RST) // R15
        s_steal_done |=> !MEM_REQ ##1 !MEM_REQ) else $error("bus not released");
    a_burst_holds: assert property (@(posedge CLK) disable iff (SYS_RST) // R16
        xfer_done && stay |=> state_reg == S_RD ##1 MEM_REQ && BUS_LOCK) else $error("burst dropped bus");
    a_io_high_ones: assert property (@(posedge CLK) disable iff (SYS_RST) // R6
        state_reg == S_RD && MEM_REQ && short_m && rx_dir |-> MEM_ADDR[23:8] == IO_HIGH_ONES)
        else $error("io address upper bits wrong");
    a_idle_mar_fixed: assert property (@(posedge CLK) disable iff (SYS_RST) // R11
        xfer_done && cm == 3'(M_IDLE) && !wb_wr |=> $stable(mar_reg[cur_reg])) else $error("idle address moved");
    a_io_step_size: assert property (@(posedge CLK) disable iff (SYS_RST) // R20
        xfer_done && cm == 3'(M_IO) && !wb_wr && !ctl_reg[cur_reg][CTL_DEC] |=>
        mar_reg[cur_reg] == $past(mar_reg[cur_reg]) + ($past(cw) ? 24'h000002 : 24'h000001))
        else $error("io step wrong");
    a_repeat_no_irq: assert property (@(posedge CLK) disable iff (SYS_RST) // R13
        xfer_done && cm == 3'(M_REPEAT) |=> DONE_IRQ == '0) else $error("repeat raised completion");
endmodule // dma_channel_engine
`default_nettype wire

// ==== core/dma_pkg.sv ====
// Purpose: constants shared by the transfer controller channel engine
// Assumes: 32-bit classic Wishbone register access, one clock
// Notes: channel c owns four words at c*16; pairs are channels 2k (A) and 2k+1 (B)
package dma_pkg;
    // register map, byte offsets
    localparam logic [7:0] OFF_MEMORY_ADDRESS = 8'h00;
    localparam logic [7:0] OFF_SHORT_IO_ADDRESS = 8'h04;
    localparam logic [7:0] OFF_TRANSFER_COUNT = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0c;
    localparam logic [7:0] OFF_MASTER_ENABLE = 8'h40;
    localparam int CH_STRIDE_LOG2 = 4;
    // control field positions
    localparam int CTL_ENABLE = 0;
    localparam int CTL_WORD = 1;
    localparam int CTL_DEC = 2;
    localparam int CTL_STEP_EN = 3;
    localparam int CTL_IRQ_EN = 4;
    localparam int CTL_MODE_LO = 5;
    localparam int CTL_TRIG_LO = 8;
    localparam int CTL_SRC_BLOCK = 11;
    localparam int CTL_W = 12;
    // reset values
    localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;
    localparam logic [23:0] MAR_RESET = 24'h000000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // fixed upper sixteen bits of the io-side address
    localparam logic [15:0] IO_HIGH_ONES = 16'hffff;
    // transfer modes
    typedef enum logic [2:0] {
        M_IO, M_IDLE, M_REPEAT, M_AUTO_BURST, M_AUTO_STEAL, M_NORMAL_EXT, M_BLOCK, M_SPARE
    } mode_t;
    // trigger selections
    localparam logic [2:0] TRIG_TXE = 3'h4;
    localparam logic [2:0] TRIG_RXF = 3'h5;
    localparam logic [2:0] TRIG_EXT = 3'h6;
    typedef enum logic [1:0] {S_IDLE, S_RD, S_WR} eng_t;
endpackage

// ==== tb/mem_model.sv ====
// Purpose: memory-side partner for the engine's master port
// Assumes: one ack pulse per phase, after LAT waiting cycles
// Notes: off-ack read data is inverted so a stale value never matches
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // engine side
    input wire logic MEM_REQ,
    input wire logic [23:0] MEM_ADDR,
    input wire logic [3:0] LAT,
    output logic [15:0] MEM_RDATA,
    output logic MEM_ACK
);
    logic [3:0] wait_reg;
    logic [15:0] val;
    assign val = MEM_ADDR[15:0] ^ 16'h5a5a;
    assign MEM_RDATA = MEM_ACK ? val : ~val;
    always_ff @(posedge CLK) begin
        if (SYS_RST || MEM_ACK || !MEM_REQ) wait_reg <= 4'h0;
        else if (wait_reg != LAT) wait_reg <= wait_reg + 4'h1;
    end
    // slow or prompt answer, set by the bench
    always_ff @(posedge CLK) MEM_ACK <= !SYS_RST && !MEM_ACK && MEM_REQ && (wait_reg == LAT);
endmodule // mem_model
`default_nettype wire

// ==== tb/tb_dma_channel_engine.sv ====
// Purpose: register-level bench for the transfer controller engine
// Assumes: mem_model answers the memory port
// Notes: io mode on channel 0, idle mode on channel 1
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_engine import dma_pkg::*; ();
    logic CLK = 0, SYS_RST = 1, cyc = 0, stb = 0, we = 0, txe = 0, rxf = 0, yield = 0, ack, req, mwe, mword, lock;
    logic mack, lk;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] tmr = 4'h0, lat = 4'h0, irq, ir;
    logic [1:0] ext_n = 2'h3, wz;
    logic [23:0] maddr, ra, wa;
    logic [15:0] mwd, mrd, wd;
    int err_count = 0, samples_checked = 0;
    dma_channel_engine #(.NCH(4)) dma_channel_engine_inst (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .TMR_MATCH(tmr), .SER_TXE(txe), .SER_RXF(rxf), .EXT_REQ_N(ext_n), .MEM_REQ(req),
        .MEM_WE(mwe), .MEM_WORD(mword), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack),
        .BUS_YIELD(yield), .BUS_LOCK(lock), .DONE_IRQ(irq));
    mem_model mem_model_inst (.CLK(CLK), .SYS_RST(SYS_RST), .MEM_REQ(req), .MEM_ADDR(maddr), .LAT(lat),
        .MEM_RDATA(mrd), .MEM_ACK(mack));
    ////////////////////////////////////////////////////////////////
    initial forever #20 CLK = ~CLK;
    task give_verdict;
        if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        n = 0;
        do begin @(posedge CLK); n++; end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task get(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // reading with enable clear arms the following write of one
    task arm_on(input logic [7:0] a, input logic [31:0] d);
        wb(1'b0, a, 32'h0);
        wb(1'b1, a, d);
    endtask
    // one request pulse, then follow the unit to its write ack
    task xfer(input logic from_rx);
        int n;
        @(posedge CLK);
        if (from_rx) rxf <= 1'b1;
        else tmr <= 4'h1;
        n = 0; ir = 4'h0;
        do begin
            @(posedge CLK); n++; tmr <= 4'h0; rxf <= 1'b0;
            if (mack === 1'b1 && mwe === 1'b0) ra = maddr;
            if (mack === 1'b1 && mwe === 1'b0) wz = {lock, mword};
        end while (!(mack === 1'b1 && mwe === 1'b1) && n < 200);
        wa = maddr; wd = mwd;
        repeat (4) begin @(posedge CLK); ir = ir | irq; end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        get(OFF_MEMORY_ADDRESS, 32'h0);
        get(8'h60, 32'h0); // unmapped
        wb(1'b1, OFF_MEMORY_ADDRESS, 32'h001000); wb(1'b1, OFF_SHORT_IO_ADDRESS, 32'h34);
        wb(1'b1, OFF_TRANSFER_COUNT, 32'h2); wb(1'b1, OFF_CONTROL, 32'h010);
        arm_on(OFF_MASTER_ENABLE, 32'h1); arm_on(OFF_CONTROL, 32'h011);
        lat = 4'h3; xfer(1'b0); chk(32'(wz), 32'h0);
        chk(32'(ra), 32'h001000); chk(32'(wa), 32'hffff34); chk(32'(wd[7:0]), 32'h5a); chk(32'(ir), 32'h0);
        lat = 4'h0; xfer(1'b0);
        chk(32'(ra), 32'h001001); chk(32'(wa), 32'hffff34); chk(32'(wd[7:0]), 32'h5b); chk(32'(ir), 32'h1);
        get(OFF_MEMORY_ADDRESS, 32'h001002); get(OFF_TRANSFER_COUNT, 32'h0); get(OFF_CONTROL, 32'h010);
        // zero count means a full 65536 run, so one unit leaves it running
        wb(1'b1, OFF_CONTROL, 32'h016); arm_on(OFF_CONTROL, 32'h017);
        xfer(1'b0); chk(32'(ra), 32'h001002); chk(32'(wd), 32'h4a58); chk(32'(ir), 32'h0);
        chk(32'(wz), 32'h1);
        get(OFF_TRANSFER_COUNT, 32'hffff); get(OFF_MEMORY_ADDRESS, 32'h001000); get(OFF_CONTROL, 32'h017);
        wb(1'b1, 8'h10, 32'h002000); wb(1'b1, 8'h14, 32'h80); wb(1'b1, 8'h18, 32'h1); wb(1'b1, 8'h1c, 32'h522);
        arm_on(8'h1c, 32'h523);
        xfer(1'b1); chk(32'(ra), 32'hffff80); chk(32'(wa), 32'h002000); chk(32'(wd), 32'ha5da);
        chk(32'(ir), 32'h2); get(8'h10, 32'h002000); get(8'h1c, 32'h522);
        // repeat mode: a one-unit run rewinds the address and reloads the count, no completion
        wb(1'b1, 8'h18, 32'h101); wb(1'b1, 8'h1c, 32'h540); arm_on(8'h1c, 32'h541);
        xfer(1'b1); chk(32'(wa), 32'h002000); chk(32'(ir), 32'h0); chk(32'(wz), 32'h0);
        get(8'h10, 32'h002000); get(8'h18, 32'h101); get(8'h1c, 32'h541);
        // full address pair 1: auto burst of two units, both addresses stepped
        wb(1'b1, 8'h20, 32'h003000); wb(1'b1, 8'h30, 32'h004000); wb(1'b1, 8'h28, 32'h2);
        wb(1'b1, 8'h3c, 32'h008); wb(1'b1, 8'h2c, 32'h078); wb(1'b1, OFF_MASTER_ENABLE, 32'h3);
        arm_on(8'h2c, 32'h079); ir = 4'h0; lk = 1'b0;
        repeat (40) begin @(posedge CLK); ir = ir | irq; lk = lk | lock; end
        chk(32'(ir), 32'h4); chk(32'(lk), 32'h1);
        get(8'h20, 32'h003002); get(8'h30, 32'h004002); get(8'h2c, 32'h078);
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        give_verdict;
    end
endmodule // tb_dma_channel_engine
`default_nettype wire
